// file: hdl/ism_cfg.svh
// Constants of the indicator status monitor
`ifndef ISM_CFG_SVH
`define ISM_CFG_SVH

// ****************************************
// Sizes
// ****************************************
`define ISM_N_IND        5
`define ISM_EVT_DEPTH    16
`define ISM_NSIG         4
`define ISM_SLOT_W       8

// ****************************************
// Timing
// ****************************************
`define ISM_CLK_NS       100
`define ISM_TS_RES_NS    1000000
`define ISM_MS_CYCLES    ((`ISM_TS_RES_NS + `ISM_CLK_NS - 1) / `ISM_CLK_NS)

// ****************************************
// Register byte addresses
// ****************************************
`define ISM_A_CTRL       8'h00
`define ISM_A_CFG        8'h04
`define ISM_A_STATE      8'h08
`define ISM_A_TIME       8'h0c
`define ISM_A_EVT        8'h10
`define ISM_A_EVCNT      8'h14
`define ISM_A_ISTAT      8'h18
`define ISM_A_IMASK      8'h1c

// ****************************************
// Fields and reset values
// ****************************************
`define ISM_CTRL_RUN     0
`define ISM_CFG_SGL_LSB  0
`define ISM_CFG_SEL_LSB  8
`define ISM_SEL_W        8
`define ISM_SEL_RST      8'hff
`define ISM_SIG_RST      4'h8
`define ISM_EV_TS_W      16
`define ISM_EV_SIG_LSB   16
`define ISM_EV_IND_LSB   20
`define ISM_EV_ON_BIT    24
`define ISM_EV_VLD_BIT   31
`define ISM_IRQ_W        3
`define ISM_IRQ_STORED   0
`define ISM_IRQ_LOST     1
`define ISM_IRQ_BAD      2
`define ISM_SIG_OPEN     0
`define ISM_SIG_CLOSE    1
`define ISM_SIG_BAD      2
`define ISM_SIG_INTER    3

// ****************************************
// Bus decode and pending slot layout
// ****************************************
`define ISM_A_W          8
`define ISM_SIG_W        2
`define ISM_SLOT_ON      2
`define ISM_SLOT_SH      3

`endif

// file: hdl/ism_pkg.sv
// Types of the indicator status monitor
package ism_pkg;
   typedef enum logic [1:0] {ISM_INTER, ISM_OPEN, ISM_CLOSED, ISM_BAD} ism_state_e;
   typedef logic [31:0] ism_word_t;
endpackage

// file: hdl/ism_stamp.sv
// Millisecond time stamp counter
`timescale 1ns/1ps
`include "ism_cfg.svh"
module ism_stamp #(
   parameter int MS_CYCLES = `ISM_MS_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   output ism_pkg::ism_word_t ms_r,
   output logic             tick
);
   import ism_pkg::*;
   localparam int CW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

   logic [CW-1:0] cyc_r;

   if (MS_CYCLES < 1) begin : g_chk
      $error("MS_CYCLES must be at least one");
   end

   assign tick = (cyc_r == CW'(MS_CYCLES - 1));

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cyc_r <= '0;
      end else if (tick) begin
         cyc_r <= '0;
      end else begin
         cyc_r <= cyc_r + 1'b1;
      end
   end

   // Wraps after about 49 days
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ms_r <= '0;
      end else if (tick) begin
         ms_r <= ms_r + 32'h0000_0001;
      end
   end

   a_ms_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
      tick |=> ms_r == $past(ms_r) + 32'h0000_0001) else $error("ms count did not step on tick");
   a_ms_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !tick |=> $stable(ms_r)) else $error("ms count moved without tick");
endmodule // ism_stamp

// file: hdl/ism_decode.sv
// One indicator: input sync, state decode and edge events
`timescale 1ns/1ps
`include "ism_cfg.svh"
module ism_decode (
   input  wire logic          ref_clk,
   input  wire logic          rst_b,
   input  wire logic          open_pin,
   input  wire logic          close_pin,
   input  wire logic          single_mode,
   input  wire logic          run,
   output ism_pkg::ism_state_e state_r,
   output logic [3:0]         sig_r,
   output logic [3:0]         rise,
   output logic [3:0]         fall
);
   import ism_pkg::*;

   logic       open_m_r;
   logic       open_s_r;
   logic       close_m_r;
   logic       close_s_r;
   logic       close_eff;
   ism_state_e state_nxt;
   logic [3:0] sig_nxt;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         open_m_r  <= 1'b0;
         open_s_r  <= 1'b0;
         close_m_r <= 1'b0;
         close_s_r <= 1'b0;
      end else begin
         open_m_r  <= open_pin;
         open_s_r  <= open_m_r;
         close_m_r <= close_pin;
         close_s_r <= close_m_r;
      end
   end

   // Single contact: closed is simply not open
   assign close_eff = single_mode ? ~open_s_r : close_s_r;

   always_comb begin
      case ({open_s_r, close_eff})
         2'b00:   state_nxt = ISM_INTER;
         2'b10:   state_nxt = ISM_OPEN;
         2'b01:   state_nxt = ISM_CLOSED;
         2'b11:   state_nxt = ISM_BAD;
         default: state_nxt = ISM_INTER;
      endcase
      sig_nxt = '0;
      case (state_nxt)
         ISM_OPEN:   sig_nxt[`ISM_SIG_OPEN]  = 1'b1;
         ISM_CLOSED: sig_nxt[`ISM_SIG_CLOSE] = 1'b1;
         ISM_BAD:    sig_nxt[`ISM_SIG_BAD]   = 1'b1;
         default:    sig_nxt[`ISM_SIG_INTER] = 1'b1;
      endcase
   end

   // Status only; nothing here drives a switching command
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_r <= ISM_INTER;
         sig_r   <= `ISM_SIG_RST;
      end else begin
         state_r <= state_nxt;
         sig_r   <= sig_nxt;
      end
   end

   assign rise = sig_nxt & ~sig_r & {4{run}};
   assign fall = ~sig_nxt & sig_r & {4{run}};

   a_inter_state: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!open_s_r && !close_eff) |=> state_r == ISM_INTER) else $error("intermediate not reported");
   a_bad_state: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (open_s_r && close_eff) |=> state_r == ISM_BAD && sig_r[`ISM_SIG_BAD]) else $error("bad not reported");
   a_open_state: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (open_s_r && !close_eff) |=> state_r == ISM_OPEN) else $error("open not reported");
   a_close_state: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!open_s_r && close_eff) |=> state_r == ISM_CLOSED) else $error("closed not reported");
   a_single_inv: assert property (@(posedge ref_clk) disable iff (!rst_b)
      single_mode ##1 single_mode |-> state_r == ISM_OPEN || state_r == ISM_CLOSED)
      else $error("single input gave a two-input state");
endmodule // ism_decode

// file: hdl/ism_top.sv
// Indicator status monitor with event store and AHB-Lite registers
`timescale 1ns/1ps
`include "ism_cfg.svh"

module ism_top #(
   parameter int N_IND     = `ISM_N_IND,
   parameter int EVT_DEPTH = `ISM_EVT_DEPTH,
   parameter int MS_CYCLES = `ISM_MS_CYCLES
) (
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   input  wire logic [N_IND-1:0]   open_pin,
   input  wire logic [N_IND-1:0]   close_pin,
   output logic [2*N_IND-1:0]      ind_state,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  ism_pkg::ism_word_t      hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output ism_pkg::ism_word_t      hrdata,
   output logic                    hresp,
   output logic                    irq
);
   import ism_pkg::*;

   // ****************************************
   // Sizes and checks
   // ****************************************
   localparam int NS = N_IND * `ISM_SLOT_W;
   localparam int PW = $clog2(EVT_DEPTH);
   localparam int IW = $clog2(NS);

   if (N_IND < 1 || N_IND > 8) begin : g_chk_ind
      $error("N_IND must lie in 1..8");
   end
   if (EVT_DEPTH < 2 || (EVT_DEPTH & (EVT_DEPTH - 1)) != 0) begin : g_chk_dep
      $error("EVT_DEPTH must be a power of two, at least 2");
   end

   // ****************************************
   // Declarations
   // ****************************************
   logic                       run_r;
   logic [N_IND-1:0]           single_r;
   logic [`ISM_SEL_W-1:0]      evsel_r;
   logic [`ISM_IRQ_W-1:0]      istat_r;
   logic [`ISM_IRQ_W-1:0]      imask_r;
   logic [`ISM_IRQ_W-1:0]      iset;
   logic [`ISM_IRQ_W-1:0]      iclr;
   ism_word_t                  ms_r;
   ism_word_t                  rd_nxt;
   logic                       ap_valid;
   logic                       dp_wr_r;
   logic [`ISM_A_W-1:0]        dp_addr_r;
   logic [NS-1:0]              pend_r;
   logic [NS-1:0]              pend_set;
   logic [NS-1:0]              pend_clr;
   logic                       pick_vld;
   logic [IW-1:0]              pick_idx;
   logic [N_IND-1:0]           bad_rise;
   ism_word_t                  mem_r [EVT_DEPTH];
   logic [PW-1:0]              wr_ptr_r;
   logic [PW-1:0]              rd_ptr_r;
   logic [PW:0]                cnt_r;
   logic                       full;
   logic                       push;
   logic                       pop;
   ism_word_t                  rec;

   // ****************************************
   // Time stamp
   // ****************************************
   ism_stamp #(
      .MS_CYCLES (MS_CYCLES)
   ) u_stamp (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .ms_r    (ms_r),
      .tick    ()
   );

   // ****************************************
   // Indicator monitors
   // ****************************************
   for (genvar i = 0; i < N_IND; i++) begin : g_ind
      ism_state_e st;
      logic [3:0] rise;
      logic [3:0] fall;

      ism_decode u_dec (
         .ref_clk     (ref_clk),
         .rst_b       (rst_b),
         .open_pin    (open_pin[i]),
         .close_pin   (close_pin[i]),
         .single_mode (single_r[i]),
         .run         (run_r),
         .state_r     (st),
         .sig_r       (),
         .rise        (rise),
         .fall        (fall)
      );

      assign ind_state[2*i +: 2] = st;
      assign bad_rise[i]         = rise[`ISM_SIG_BAD];
      // Upper nibble of a slot holds ON events, lower nibble OFF events
      assign pend_set[i*`ISM_SLOT_W +: `ISM_SLOT_W] =
         {rise & evsel_r[`ISM_NSIG-1:0], fall & evsel_r[`ISM_SEL_W-1:`ISM_NSIG]};
   end

   // ****************************************
   // Pending events and picker
   // ****************************************
   // Lowest slot first; a full scan is far shorter than one millisecond
   always_comb begin
      pick_vld = 1'b0;
      pick_idx = '0;
      for (int k = NS - 1; k >= 0; k--) begin
         if (pend_r[k]) begin
            pick_vld = 1'b1;
            pick_idx = IW'(k);
         end
      end
   end

   always_comb begin
      pend_clr = '0;
      if (pick_vld) begin
         pend_clr[pick_idx] = 1'b1;
      end
   end

   // A new edge outranks the clear of its own slot
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pend_r <= '0;
      end else begin
         pend_r <= (pend_r & ~pend_clr) | pend_set;
      end
   end

   // ****************************************
   // Event store
   // ****************************************
   assign full = (cnt_r == (PW+1)'(EVT_DEPTH));
   assign push = pick_vld && !full;
   assign pop  = ap_valid && !hwrite && haddr[`ISM_A_W-1:0] == `ISM_A_EVT && cnt_r != '0;

   always_comb begin
      rec = '0;
      rec[`ISM_EV_TS_W-1:0]          = ms_r[`ISM_EV_TS_W-1:0];
      rec[`ISM_EV_SIG_LSB +: `ISM_SIG_W] = pick_idx[`ISM_SIG_W-1:0];
      rec[`ISM_EV_IND_LSB +: 3]      = 3'(pick_idx >> `ISM_SLOT_SH);
      rec[`ISM_EV_ON_BIT]            = pick_idx[`ISM_SLOT_ON];
      rec[`ISM_EV_VLD_BIT]           = 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= rec;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   // ****************************************
   // Interrupt status
   // ****************************************
   assign iset[`ISM_IRQ_STORED] = push;
   assign iset[`ISM_IRQ_LOST]   = pick_vld && full;
   assign iset[`ISM_IRQ_BAD]    = |bad_rise;
   assign iclr = (dp_wr_r && dp_addr_r == `ISM_A_ISTAT) ? hwdata[`ISM_IRQ_W-1:0] : '0;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         istat_r <= '0;
      end else begin
         istat_r <= (istat_r & ~iclr) | iset;
      end
   end

   assign irq = |(istat_r & imask_r);

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   // Zero wait states; read data is taken during the address phase
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign ap_valid  = hsel && htrans[1] && hready;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         dp_wr_r   <= 1'b0;
         dp_addr_r <= '0;
      end else begin
         dp_wr_r   <= ap_valid && hwrite;
         dp_addr_r <= haddr[`ISM_A_W-1:0];
      end
   end

   always_comb begin
      rd_nxt = '0;
      case (haddr[`ISM_A_W-1:0])
         `ISM_A_CTRL:  rd_nxt[`ISM_CTRL_RUN] = run_r;
         `ISM_A_CFG: begin
            rd_nxt[`ISM_CFG_SGL_LSB +: N_IND]      = single_r;
            rd_nxt[`ISM_CFG_SEL_LSB +: `ISM_SEL_W] = evsel_r;
         end
         `ISM_A_STATE: rd_nxt[2*N_IND-1:0] = ind_state;
         `ISM_A_TIME:  rd_nxt = ms_r;
         `ISM_A_EVT: begin
            if (cnt_r != '0) begin
               rd_nxt = mem_r[rd_ptr_r];
            end
         end
         `ISM_A_EVCNT: rd_nxt[PW:0] = cnt_r;
         `ISM_A_ISTAT: rd_nxt[`ISM_IRQ_W-1:0] = istat_r;
         `ISM_A_IMASK: rd_nxt[`ISM_IRQ_W-1:0] = imask_r;
         default:      rd_nxt = '0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         hrdata <= '0;
      end else if (ap_valid && !hwrite) begin
         hrdata <= rd_nxt;
      end
   end

   // ****************************************
   // Control and setup registers
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         run_r   <= 1'b0;
         imask_r <= '0;
      end else if (dp_wr_r) begin
         if (dp_addr_r == `ISM_A_CTRL) begin
            run_r <= hwdata[`ISM_CTRL_RUN];
         end
         if (dp_addr_r == `ISM_A_IMASK) begin
            imask_r <= hwdata[`ISM_IRQ_W-1:0];
         end
      end
   end

   // Setup is frozen while monitoring runs
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         single_r <= '0;
         evsel_r  <= `ISM_SEL_RST;
      end else if (dp_wr_r && dp_addr_r == `ISM_A_CFG && !run_r) begin
         single_r <= hwdata[`ISM_CFG_SGL_LSB +: N_IND];
         evsel_r  <= hwdata[`ISM_CFG_SEL_LSB +: `ISM_SEL_W];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence s_cfg_write;
      dp_wr_r && dp_addr_r == `ISM_A_CFG;
   endsequence

   // An edge of a disabled kind must never reach the pending slots
   sequence s_unselected_edge;
      (pend_set & ~{N_IND{evsel_r[`ISM_NSIG-1:0], evsel_r[`ISM_SEL_W-1:`ISM_NSIG]}}) != '0;
   endsequence

   a_cfg_frozen: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_cfg_write ##0 run_r |=> $stable(single_r) && $stable(evsel_r)) else $error("setup changed while running");
   a_evsel_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
      run_r |-> not s_unselected_edge) else $error("unselected event pending");
   a_evt_pend: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (pend_set != '0) |=> (pend_r & $past(pend_set)) == $past(pend_set)) else $error("event edge lost");
   a_evt_stamp: assert property (@(posedge ref_clk) disable iff (!rst_b)
      push |=> mem_r[$past(wr_ptr_r)][`ISM_EV_TS_W-1:0] == $past(ms_r[`ISM_EV_TS_W-1:0]))
      else $error("event stored without its time stamp");
endmodule // ism_top

// file: sim/ism_contacts.sv
// Switchgear auxiliary contact model feeding the monitor pins
`timescale 1ns/1ps
module ism_contacts #(
   parameter int N_IND = 5,
   parameter int LAG   = 2
) (
   input  wire logic [2*N_IND-1:0] ref_clk_pos,
   input  wire logic               ref_clk,
   output logic [N_IND-1:0]        open_pin,
   output logic [N_IND-1:0]        close_pin
);
   // ****
   // Contact travel
   // ****
   // Pipeline stands in for mechanical lag; contacts never float
   logic [2*N_IND-1:0] pipe_r [LAG];
   always_ff @(posedge ref_clk) begin
      pipe_r[0] <= ref_clk_pos;
      for (int k = 1; k < LAG; k++) begin
         pipe_r[k] <= pipe_r[k-1];
      end
   end
   always_comb begin
      for (int i = 0; i < N_IND; i++) begin
         open_pin[i]  = pipe_r[LAG-1][2*i];
         close_pin[i] = pipe_r[LAG-1][2*i+1];
      end
   end
endmodule // ism_contacts

// file: sim/tb_top.sv
// Testbench of the indicator status monitor
`timescale 1ns/1ps
`include "ism_cfg.svh"
module tb_top;
   import ism_pkg::*;
   localparam int MS = 10;
   logic       ref_clk;
   logic       rst_b;
   logic [9:0] pos;
   logic [9:0] p;
   logic [4:0] open_pin;
   logic [4:0] close_pin;
   logic [9:0] ind_state;
   logic       hsel;
   logic       hwrite;
   logic       hreadyout;
   logic       hresp;
   logic       irq;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   ism_word_t  hwdata;
   ism_word_t  hrdata;
   ism_word_t  rd;
   ism_word_t  t0;
   logic [15:0] stamp;
   int         error_cnt = 0;
   int         samples_checked = 0;

   ism_top #(.N_IND(5), .EVT_DEPTH(16), .MS_CYCLES(MS)) ism_top_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .open_pin(open_pin), .close_pin(close_pin),
      .ind_state(ind_state), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .irq(irq));
   ism_contacts #(.N_IND(5), .LAG(2)) ism_contacts_inst (
      .ref_clk_pos(pos), .ref_clk(ref_clk), .open_pin(open_pin), .close_pin(close_pin));

   // ****
   // Clock and watchdog
   // ****
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      error_cnt++;
      complete_run;
   end

   // ****
   // Tasks
   // ****
   task complete_run;
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input ism_word_t got, input ism_word_t exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Single word transfer; waits on hready rather than a fixed latency
   task bus(input logic w, input logic [7:0] a, input ism_word_t d);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task wr(input logic [7:0] a, input ism_word_t d);
      bus(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input ism_word_t exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task pop(input logic [2:0] ind, input logic [1:0] sig, input logic on);
      bus(1'b0, `ISM_A_EVT, 32'h0);
      chk(rd & 32'hffff0000, {1'b1, 6'h0, on, 1'b0, ind, 2'b0, sig, 16'h0});
   endtask
   task move(input logic [9:0] np, input int n);
      @(posedge ref_clk);
      pos <= np;
      repeat (n) @(posedge ref_clk);
   endtask
   task irq_chk(input logic exp);
      @(negedge ref_clk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   // ****
   // Tests
   // ****
   // One process drives rst_b, pos and every bus input but hready, so each has a single driver
   initial begin
      rst_b = 1'b0;
      pos = 10'h000;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      rdc(`ISM_A_CTRL, 32'h0);
      rdc(`ISM_A_CFG, 32'h0000ff00);
      rdc(`ISM_A_EVT, 32'h0);
      rdc(`ISM_A_ISTAT, 32'h0);
      rdc(`ISM_A_IMASK, 32'h0);
      wr(8'h20, 32'hffffffff);
      rdc(8'h20, 32'h0);
      chk({29'h0, hreadyout, irq, hresp}, 32'h4);
      // Each indicator walks all four codes while its neighbours differ
      for (int i = 0; i < 5; i++) begin
         for (int s = 0; s < 4; s++) begin
            p = {5{2'(s + 1)}};
            p[2*i+:2] = 2'(s);
            move(p, 8);
            rdc(`ISM_A_STATE, {22'h0, p});
            chk({22'h0, ind_state}, {22'h0, p});
         end
      end
      rdc(`ISM_A_EVCNT, 32'h0);
      wr(`ISM_A_CFG, 32'h0000ff1f);
      rdc(`ISM_A_CFG, 32'h0000ff1f);
      move(10'h3ff, 8);
      rdc(`ISM_A_STATE, 32'h155);
      move(10'h000, 8);
      rdc(`ISM_A_STATE, 32'h2aa);
      // ON only, then OFF only, then both
      wr(`ISM_A_CFG, 32'h00000f00);
      move(10'h2aa, 8);
      wr(`ISM_A_IMASK, 32'h7);
      wr(`ISM_A_CTRL, 32'h1);
      bus(1'b0, `ISM_A_TIME, 32'h0);
      t0 = rd;
      move(10'h29a, 50);
      pop(3'd2, 2'd0, 1'b1);
      stamp = rd[15:0];
      bus(1'b0, `ISM_A_TIME, 32'h0);
      chk({31'h0, stamp >= t0[15:0] && stamp <= rd[15:0]}, 32'h1);
      irq_chk(1'b1);
      wr(`ISM_A_ISTAT, 32'h1);
      irq_chk(1'b0);
      wr(`ISM_A_CFG, 32'h0000f000);
      rdc(`ISM_A_CFG, 32'h00000f00);
      wr(`ISM_A_CTRL, 32'h0);
      wr(`ISM_A_CFG, 32'h0000f000);
      wr(`ISM_A_CTRL, 32'h1);
      move(10'h2aa, 50);
      pop(3'd2, 2'd0, 1'b0);
      rdc(`ISM_A_EVT, 32'h0);
      wr(`ISM_A_CTRL, 32'h0);
      wr(`ISM_A_CFG, 32'h0000ff00);
      wr(`ISM_A_CTRL, 32'h1);
      move(10'h3aa, 50);
      rdc(`ISM_A_EVCNT, 32'h2);
      pop(3'd4, 2'd1, 1'b0);
      pop(3'd4, 2'd2, 1'b1);
      rdc(`ISM_A_ISTAT, 32'h5);
      move(10'h3a8, 50);
      pop(3'd0, 2'd1, 1'b0);
      pop(3'd0, 2'd3, 1'b1);
      // Overfill the store: 18 events into 16 places
      wr(`ISM_A_ISTAT, 32'h7);
      wr(`ISM_A_IMASK, 32'h2);
      for (int k = 0; k < 9; k++) begin
         move((k % 2 == 0) ? 10'h3a9 : 10'h3a8, 50);
      end
      rdc(`ISM_A_EVCNT, 32'h10);
      rdc(`ISM_A_ISTAT, 32'h3);
      irq_chk(1'b1);
      wr(`ISM_A_IMASK, 32'h0);
      irq_chk(1'b0);
      pop(3'd0, 2'd3, 1'b0);
      for (int k = 0; k < 15; k++) begin
         bus(1'b0, `ISM_A_EVT, 32'h0);
      end
      rdc(`ISM_A_EVCNT, 32'h0);
      rdc(`ISM_A_EVT, 32'h0);
      // Reads sit 203 cycles apart
      bus(1'b0, `ISM_A_TIME, 32'h0);
      t0 = rd;
      repeat (200) @(posedge ref_clk);
      bus(1'b0, `ISM_A_TIME, 32'h0);
      chk({31'h0, (rd - t0 == 32'h14) || (rd - t0 == 32'h15)}, 32'h1);
      complete_run;
   end
endmodule // tb_top
